// ### verilog/conv_sequencer.sv
// conv_sequencer: converter control and result registers on Wishbone
// assumes: classic Wishbone master, analog core answers on core_result
// assumes: core_result holds still from core_sample to completion
`timescale 1ns/100ps
`include "conv_ctrl_regs.svh"

// ****************************************************************
// converter control, result pair and conversion timing
// ****************************************************************

module conv_sequencer
   import conv_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic global_irq_enable,
   input wire logic irq_vector_taken,
   input wire logic [9:0] core_result,
   output logic core_power,
   output logic core_sample,
   output logic [2:0] core_channel,
   output logic [1:0] core_reference,
   output logic conv_busy,
   output logic done_irq
);
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      conv_state_t st;
      logic on;
      logic go;
      logic cont;
      logic done;
      logic irqen;
      logic [2:0] div_sel;
      logic [1:0] refsel;
      logic left;
      logic [2:0] mux;
      logic [1:0] act_ref;
      logic [2:0] act_mux;
      logic need_ext;
      logic odd_edge;
      logic [4:0] cnt;
      logic [9:0] result;
      logic locked;
      logic [9:0] pend;
      logic pend_v;
      logic ack;
      logic [31:0] rdat;
      logic sample;
      logic busy;
      logic irq;
   } seq_state_t;

   seq_state_t s_q;
   seq_state_t s_d;
   conv_tick_if tk ();
   logic [7:0] wbyte;
   logic [7:0] ridx;
   logic wr_ctl;
   logic wr_sel;
   logic req;
   logic rd_req;
   logic start_ok;
   logic finish;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [15:0] align(input logic [9:0] r,
                                         input logic l);
      align = l ? {r, 6'h00} : {6'h00, r};
   endfunction

   // ****************************************************************
   // converter clock
   // ****************************************************************
   conv_prescaler u_pre (
      .ref_clk(ref_clk),
      .rst(rst),
      .tk(tk)
   );

   // ****************************************************************
   // bus decode
   // ****************************************************************
   assign tk.run = s_q.on;
   assign tk.div_sel = s_q.div_sel;
   // ack low gate keeps a held request from being taken twice
   assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
   assign rd_req = req && !wb_we_i;
   assign ridx = wb_adr_i[9:2];
   assign wbyte = wb_dat_i[7:0];
   assign wr_ctl = req && wb_we_i && wb_sel_i[0]
                   && ridx == `REG_IDX_CONTROL;
   assign wr_sel = req && wb_we_i && wb_sel_i[0]
                   && ridx == `REG_IDX_INPUT_SELECT;
   assign finish = s_q.st == ST_CONV && tk.tick && s_q.cnt == 5'h01;
   // differential starts from idle only on every other converter edge
   assign start_ok = s_q.go && tk.tick
                     && (!s_q.mux[`SEL_DIFF_BIT] || s_q.odd_edge);

   // ****************************************************************
   // sequencing and registers
   // ****************************************************************
   always_comb begin
      logic [15:0] al;
      al = align(s_q.result, s_q.left);
      s_d = s_q;
      s_d.ack = req;
      s_d.sample = 1'b0;
      if (tk.tick) begin
         s_d.odd_edge = !s_q.odd_edge;
      end

      // ************************************************************
      // register reads
      // ************************************************************
      s_d.rdat = 32'h0000_0000;
      if (rd_req) begin
         unique case (ridx)
            `REG_IDX_RESULT_LOW: begin
               s_d.rdat = {24'h00_0000, al[7:0]};
               s_d.locked = 1'b1;
            end
            `REG_IDX_RESULT_HIGH: begin
               s_d.rdat = {24'h00_0000, al[15:8]};
               s_d.locked = 1'b0;
               if (s_q.pend_v) begin
                  s_d.result = s_q.pend;
                  s_d.pend_v = 1'b0;
               end
            end
            `REG_IDX_CONTROL: begin
               s_d.rdat = {24'h00_0000, s_q.on, s_q.go, s_q.cont,
                           s_q.done, s_q.irqen, s_q.div_sel};
            end
            `REG_IDX_INPUT_SELECT: begin
               s_d.rdat = {24'h00_0000, s_q.refsel, s_q.left,
                           2'h0, s_q.mux};
            end
            default: begin
               s_d.rdat = 32'h0000_0000;
            end
         endcase
      end

      // ************************************************************
      // register writes
      // ************************************************************
      if (wr_ctl) begin
         s_d.on = wbyte[`CTL_ON_BIT];
         s_d.cont = wbyte[`CTL_CONT_BIT];
         s_d.irqen = wbyte[`CTL_IRQEN_BIT];
         s_d.div_sel = wbyte[2:0];
         if (wbyte[`CTL_GO_BIT]) begin
            s_d.go = 1'b1;
         end
         if (wbyte[`CTL_DONE_BIT]) begin
            s_d.done = 1'b0;
         end
         // enable edge restarts the extended count and edge parity
         if (wbyte[`CTL_ON_BIT] && !s_q.on) begin
            s_d.need_ext = 1'b1;
            s_d.odd_edge = 1'b0;
         end
      end
      if (wr_sel) begin
         s_d.refsel = wbyte[7:6];
         s_d.left = wbyte[`SEL_LEFT_BIT];
         s_d.mux = wbyte[2:0];
      end
      if (irq_vector_taken) begin
         s_d.done = 1'b0;
      end

      // ************************************************************
      // conversion engine
      // ************************************************************
      unique case (s_q.st)
         ST_OFF: begin
            if (s_q.on) begin
               s_d.st = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (start_ok) begin
               s_d.st = ST_CONV;
               s_d.act_mux = s_q.mux;
               s_d.act_ref = s_q.refsel;
               s_d.sample = 1'b1;
               if (s_q.need_ext || s_q.refsel != s_q.act_ref
                   || (s_q.mux[`SEL_DIFF_BIT]
                       && s_q.mux != s_q.act_mux)) begin
                  s_d.cnt = `CONV_EXTENDED_CLKS;
               end else begin
                  s_d.cnt = `CONV_NORMAL_CLKS;
               end
               s_d.need_ext = 1'b0;
            end
         end
         ST_CONV: begin
            if (tk.tick) begin
               s_d.cnt = s_q.cnt - 5'h01;
            end
            if (finish) begin
               // result comes after the gain stage of the core
               // read decode above is already folded into s_d.locked
               if (s_d.locked) begin
                  s_d.pend = core_result;
                  s_d.pend_v = 1'b1;
               end else begin
                  s_d.result = core_result;
               end
               s_d.done = 1'b1;
               // next start coincides with the completion
               if (s_q.cont) begin
                  s_d.act_mux = s_q.mux;
                  s_d.act_ref = s_q.refsel;
                  s_d.sample = 1'b1;
                  s_d.cnt = (s_q.refsel != s_q.act_ref)
                            ? `CONV_EXTENDED_CLKS
                            : `CONV_NORMAL_CLKS;
               end else begin
                  s_d.go = 1'b0;
                  s_d.st = ST_IDLE;
               end
            end
         end
      endcase

      // ************************************************************
      // power down, busy and interrupt
      // ************************************************************
      // new enable value, so one write may enable and start together
      if (!s_d.on) begin
         s_d.st = ST_OFF;
         s_d.go = 1'b0;
         s_d.sample = 1'b0;
      end
      s_d.busy = s_d.st == ST_CONV;
      // flag set above wins over a clear in the same cycle
      s_d.irq = s_d.done && s_d.irqen && global_irq_enable;
   end

   // ****************************************************************
   // register update
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.st <= ST_OFF;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign wb_dat_o = s_q.rdat;
   assign wb_ack_o = s_q.ack;
   assign core_power = s_q.on;
   assign core_sample = s_q.sample;
   assign core_channel = s_q.act_mux;
   assign core_reference = s_q.act_ref;
   assign conv_busy = s_q.busy;
   assign done_irq = s_q.irq;
endmodule // conv_sequencer

// ### verilog/conv_ctrl_regs.svh
// conv_ctrl_regs.svh: offsets, field positions and timing counts
// assumes: included by bare name from the sequencer module only
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH

// ****************************************************************
// register offsets (index, byte address is four times it)
// ****************************************************************
`define REG_IDX_RESULT_LOW 8'h04
`define REG_IDX_RESULT_HIGH 8'h05
`define REG_IDX_CONTROL 8'h06
`define REG_IDX_INPUT_SELECT 8'h07

// ****************************************************************
// control register fields
// ****************************************************************
`define CTL_ON_BIT 7
`define CTL_GO_BIT 6
`define CTL_CONT_BIT 5
`define CTL_DONE_BIT 4
`define CTL_IRQEN_BIT 3
`define CTL_RESET_VAL 8'h00

// ****************************************************************
// input select register fields
// ****************************************************************
`define SEL_LEFT_BIT 5
`define SEL_DIFF_BIT 2
`define SEL_WMASK 8'hE7

// ****************************************************************
// conversion lengths in converter clocks
// ****************************************************************
`define CONV_NORMAL_CLKS 5'h0D
`define CONV_EXTENDED_CLKS 5'h19

`endif

// ### verilog/conv_ctrl_pkg.sv
// conv_ctrl_pkg: types shared by the converter control modules
// assumes: nothing beyond the constants header
package conv_ctrl_pkg;
   typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_CONV} conv_state_t;
endpackage

// ### verilog/conv_tick_if.sv
// conv_tick_if: prescaler tick carried to the sequencer
// assumes: one clock shared by both ends
`timescale 1ns/100ps
interface conv_tick_if;
   logic run;
   logic [2:0] div_sel;
   logic tick;
   modport src (input run, input div_sel, output tick);
   modport dst (output run, output div_sel, input tick);
endinterface

// ### verilog/conv_prescaler.sv
// conv_prescaler: converter clock divider, one tick per rising edge
// assumes: run low holds the counter in reset
`timescale 1ns/100ps
module conv_prescaler
   import conv_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   conv_tick_if.src tk
);
   typedef struct packed {
      logic [6:0] cnt;
      logic tick;
   } pre_state_t;

   pre_state_t s_q;
   pre_state_t s_d;

   function automatic logic [6:0] div_last(input logic [2:0] sel);
      div_last = (sel < 3'h2) ? 7'h01 : 7'((8'h01 << sel) - 8'h01);
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (!tk.run) begin
         s_d.cnt = 7'h00;
      end else if (s_q.cnt >= div_last(tk.div_sel)) begin
         s_d.cnt = 7'h00;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 7'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tk.tick = s_q.tick;
endmodule // conv_prescaler

// ### test/conv_sequencer_asserts.sv
// conv_sequencer_asserts: port checks of the converter control
// assumes: bound to conv_sequencer, one clock, sync reset
`timescale 1ns/100ps
module conv_sequencer_asserts (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic global_irq_enable,
   input wire logic irq_vector_taken,
   input wire logic core_power,
   input wire logic core_sample,
   input wire logic conv_busy,
   input wire logic done_irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   AST_ACK_NEXT: assert property ( // [WB]
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_DAT_UPPER_ZERO: assert property (
      wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read bits set");
   AST_IRQ_MASKED: assert property (
      !global_irq_enable |=> !done_irq)
      else $error("irq while masked");
   AST_VECTOR_CLEARS: assert property (
      irq_vector_taken && !conv_busy |=> ##1 !done_irq)
      else $error("irq after vector");
   AST_SAMPLE_PULSE: assert property (
      core_sample |=> !core_sample)
      else $error("start pulse too long");
   AST_SAMPLE_POWERED: assert property (
      core_sample |-> core_power)
      else $error("start while off");
   AST_OFF_IDLE: assert property (
      !core_power ##1 !core_power |-> !conv_busy)
      else $error("busy while off");
   AST_CONV_SPAN: assert property (
      core_sample |-> ##2 (conv_busy || !core_power)[*8])
      else $error("conversion too short");
endmodule // conv_sequencer_asserts

bind conv_sequencer conv_sequencer_asserts chk_u (.ref_clk, .rst,
   .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .global_irq_enable,
   .irq_vector_taken, .core_power, .core_sample, .conv_busy, .done_irq);

// ### test/conv_core_model.sv
// conv_core_model: analog core stand-in, one new code per start
// assumes: core_sample is a one-cycle pulse
`timescale 1ns/100ps
module conv_core_model (
   input wire logic ref_clk,
   input wire logic core_power,
   input wire logic core_sample,
   output logic [9:0] core_result
);
   int n = 0;
   initial core_result = 10'h000;
   always @(posedge ref_clk) begin
      if (core_sample) begin
         // ground, full scale, then random post-gain codes
         core_result <= (n == 0) ? 10'h000 :
            (n == 1) ? 10'h3FF : 10'($urandom);
         n <= n + 1;
      end else if (!core_power) begin
         core_result <= ~core_result;
      end
   end
endmodule // conv_core_model

// ### test/tb.sv
// tb: self-checking bench of the converter control block
// assumes: conv_sequencer on Wishbone, core model on the far side
`timescale 1ns/100ps
module tb;
   logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, conv_busy;
   logic global_irq_enable, irq_vector_taken, core_power, core_sample;
   logic done_irq, samp_d;
   logic [2:0] core_channel;
   logic [1:0] core_reference;
   logic [9:0] wb_adr_i, core_result, start_val, v;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [7:0] rd;
   logic [9:0] regs [5] = '{10'h010, 10'h014, 10'h018, 10'h01C, 10'h3FC};
   int errors = 0, comparisons = 0, cycles = 0, busy_n = 0, samples = 0;
   int s0;
   conv_sequencer dut_u (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .global_irq_enable, .irq_vector_taken, .core_result, .core_power,
      .core_sample, .core_channel, .core_reference, .conv_busy,
      .done_irq);
   conv_core_model core_u (.ref_clk, .core_power, .core_sample,
      .core_result);
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // conversion length, start value and hang limit
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      samp_d <= core_sample;
      if (samp_d)
         start_val <= core_result;
      if (core_sample) begin
         busy_n <= 0;
         samples <= samples + 1;
      end else if (conv_busy === 1'b1) begin
         busy_n <= busy_n + 1;
      end
      if (cycles == 40000) begin
         errors++;
         stop_test();
      end
   end
   // ************************************************
   // bus and compare tasks
   // ************************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic wb(input logic [9:0] a, input logic w, input logic [7:0] d);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= {24'($urandom), d};
      wb_sel_i <= {3'($urandom), 1'b1};
      {wb_cyc_i, wb_stb_i} <= 2'h3;
      do
         @(posedge ref_clk);
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o[7:0];
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge ref_clk);
   endtask
   task automatic rdc(input logic [9:0] a, input logic [7:0] e);
      wb(a, 1'b0, 8'h00);
      chk(rd, e);
   endtask
   task automatic rdres(input logic l);
      rdc(10'h010, l ? {start_val[1:0], 6'h00} : start_val[7:0]);
      rdc(10'h014, l ? start_val[9:2] : {6'h00, start_val[9:8]});
   endtask
   task automatic conv(input logic [7:0] c, input int n);
      int d, e, t;
      d = 1 << (c[2:0] == 3'h0 ? 1 : c[2:0]);
      e = n * d;
      t = d / 2 + 3;
      wb(10'h018, 1'b1, c | 8'h50);
      do wb(10'h018, 1'b0, 8'h00); while (rd[4] !== 1'b1);
      chk(32'(busy_n > e - t && busy_n < e + t), 1);
   endtask
   task automatic stop_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {global_irq_enable, irq_vector_taken} = '0;
      rst = 1'b1;
      s0 = $urandom(6813);
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      wb(10'h3FC, 1'b1, 8'hFF);
      foreach (regs[i])
         rdc(regs[i], 8'h00);
      $display("test reset_values done");
      for (int k = 0; k < 8; k++) begin
         global_irq_enable <= 1'($urandom);
         wb(10'h01C, 1'b1, 8'(k[0]) << 5);
         wb(10'h018, 1'b1, 8'h00);
         conv(8'h80 | 8'(k), 25);
         rdc(10'h018, 8'h90 | 8'(k));
         rdres(k[0]);
         conv(8'h80 | 8'(k), 13);
         rdres(k[0]);
         wb(10'h018, 1'b1, 8'h90 | 8'(k));
         rdc(10'h018, 8'h80 | 8'(k));
      end
      $display("test divider_align done");
      wb(10'h01C, 1'b1, 8'h20);
      conv(8'h80, 13);
      v = start_val;
      rdc(10'h010, {v[1:0], 6'h00});
      conv(8'h80, 13);
      rdc(10'h014, v[9:2]);
      rdres(1'b1);
      $display("test result_lock done");
      wb(10'h01C, 1'b1, 8'h64);
      conv(8'h81, 25);
      chk(core_channel, 3'h4);
      chk(core_reference, 2'h1);
      conv(8'h81, 13);
      $display("test differential done");
      global_irq_enable <= 1'b1;
      conv(8'h88, 13);
      repeat (2) @(posedge ref_clk);
      chk(done_irq, 1);
      global_irq_enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(done_irq, 0);
      global_irq_enable <= 1'b1;
      irq_vector_taken <= 1'b1;
      @(posedge ref_clk);
      irq_vector_taken <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(done_irq, 0);
      rdc(10'h018, 8'h88);
      $display("test interrupt done");
      s0 = samples;
      wb(10'h018, 1'b1, 8'hE0);
      repeat (300) @(posedge ref_clk);
      wb(10'h018, 1'b1, 8'hA0);
      wb(10'h018, 1'b0, 8'h00);
      chk(rd & 8'hEF, 8'hE0);
      chk(32'(samples - s0 >= 8), 1);
      wb(10'h018, 1'b1, 8'h00);
      repeat (3) @(posedge ref_clk);
      chk(conv_busy, 0);
      s0 = samples;
      repeat (100) @(posedge ref_clk);
      chk(samples, s0);
      wb(10'h018, 1'b1, 8'hE0);
      repeat (80) @(posedge ref_clk);
      wb(10'h018, 1'b1, 8'h80);
      repeat (80) @(posedge ref_clk);
      rdc(10'h018, 8'h90);
      s0 = samples;
      repeat (60) @(posedge ref_clk);
      chk(samples, s0);
      $display("test continuous done");
      stop_test();
   end
endmodule // tb
